//--- design/mgpio_top.sv
// Purpose: Pin function, pin data and chip function control for four modem pins
// Assumes: One 50 MHz clock, synchronous active-low reset
// Notes:   Event and routing inputs come from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module mgpio_top
   import mgpio_pkg::*;
#(
   parameter int HALF_FAST = MGPIO_HALF_FAST,
   parameter int HALF_SLOW = MGPIO_HALF_SLOW
)
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Register port
   input wire logic [3:0] i_reg_index,
   input wire logic i_reg_write,
   input wire logic [7:0] i_reg_wdata,
   output logic [7:0] o_reg_rdata,
   // General pins
   input wire logic [3:0] i_pin,
   output logic [3:0] o_pin,
   output logic [3:0] o_pin_oe,
   output logic [3:0] o_analog_in_pin,
   output logic o_escape,
   // Alert causes
   input wire logic i_carrier_loss,
   input wire logic i_reversal,
   input wire logic i_wake_on_ring,
   input wire logic i_wake_report_enable,
   input wire logic i_intrusion,
   input wire logic i_intrusion_report_enable,
   input wire logic i_loop_loss,
   input wire logic i_loop_loss_report_enable,
   input wire logic i_off_hook,
   // Pin two and pin one functions
   input wire logic i_carrier_detect_output,
   input wire logic i_carrier_detect_on_pin,
   input wire logic i_frame_end_flag,
   // Serial control paths
   input wire logic i_primary_receive,
   output logic o_primary_transmit,
   input wire logic i_control_transmit,
   output logic o_control_receive,
   // Routing and analog control
   output logic [1:0] o_line_tx_src,
   output logic [1:0] o_analog_out_pin_src,
   output logic [1:0] o_processor_signal_in_src,
   output logic o_serial_loopback,
   output logic o_analog_power_on,
   output logic [1:0] o_analog_input_gain
);
   logic [7:0] pin_function_select;
   logic [7:0] pin_data_and_input_gain;
   logic [7:0] chip_functions_five;
   logic [7:0] next_pin_function_select;
   logic [7:0] next_pin_data_and_input_gain;
   logic [7:0] next_chip_functions_five;
   logic [MGPIO_SYNC_WIDTH-1:0] synced;
   logic [3:0] pin_level;
   logic [15:0] fast_count;
   logic [15:0] slow_count;
   logic baud_9600_tick;
   logic baud_600_tick;
   logic [15:0] next_fast_count;
   logic [15:0] next_slow_count;
   logic next_baud_9600_tick;
   logic next_baud_600_tick;
   logic [3:0] next_pin;
   logic [3:0] next_pin_oe;
   logic [3:0] next_analog_in_pin;
   logic next_escape;
   logic next_primary_transmit;
   logic next_control_receive;
   logic [1:0] next_line_tx_src;
   logic [1:0] next_analog_out_pin_src;
   logic [1:0] next_processor_signal_in_src;
   logic next_serial_loopback;
   logic [7:0] next_reg_rdata;
   logic alert_level;
   mgpio_mode_type mode_four;
   mgpio_mode_type mode_three;
   mgpio_mode_type mode_two;
   mgpio_mode_type mode_one;
   mgpio_route_type data_routing_select;
   logic frame_end_flag_enable;
   logic second_port_enable;

   function automatic mgpio_mode_type field_mode(input logic [7:0] sel, input int pos);
      field_mode = mgpio_mode_type'(sel[pos +: 2]);
   endfunction

   function automatic logic drives_data(input mgpio_mode_type m);
      drives_data = (m == MGPIO_MODE_OUTPUT);
   endfunction

   mgpio_sync u_sync
   (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_async({i_primary_receive, i_pin}),
      .o_sync(synced)
   );

   assign pin_level = synced[3:0];
   assign mode_four = field_mode(pin_function_select, MGPIO_FLD_PIN_FOUR);
   assign mode_three = field_mode(pin_function_select, MGPIO_FLD_PIN_THREE);
   assign mode_two = field_mode(pin_function_select, MGPIO_FLD_PIN_TWO);
   assign mode_one = field_mode(pin_function_select, MGPIO_FLD_PIN_ONE);
   assign data_routing_select =
      mgpio_route_type'(chip_functions_five[MGPIO_FLD_ROUTING +: 2]);
   assign frame_end_flag_enable = chip_functions_five[MGPIO_BIT_FRAME_END];
   assign second_port_enable = chip_functions_five[MGPIO_BIT_SECOND_PORT];

   // Register writes
   always_comb
   begin
      next_pin_function_select = pin_function_select;
      next_pin_data_and_input_gain = pin_data_and_input_gain;
      next_chip_functions_five = chip_functions_five;
      if (i_reg_write)
      begin
         case (i_reg_index)
            MGPIO_IDX_PIN_FUNCTION: next_pin_function_select = i_reg_wdata;
            MGPIO_IDX_PIN_DATA: next_pin_data_and_input_gain = i_reg_wdata & MGPIO_PIN_DATA_MASK;
            MGPIO_IDX_CHIP_FUNCTIONS:
               next_chip_functions_five = i_reg_wdata & MGPIO_CHIP_WRITE_MASK;
            default: next_pin_function_select = pin_function_select;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         pin_function_select <= MGPIO_PIN_FUNCTION_RST;
         pin_data_and_input_gain <= MGPIO_PIN_DATA_RST;
         chip_functions_five <= MGPIO_CHIP_FUNCTIONS_RST;
      end
      else
      begin
         pin_function_select <= next_pin_function_select;
         pin_data_and_input_gain <= next_pin_data_and_input_gain;
         chip_functions_five <= next_chip_functions_five;
      end
   end

   // Baud clock indications
   always_comb
   begin
      next_fast_count = fast_count + 16'h0001;
      next_slow_count = slow_count + 16'h0001;
      next_baud_9600_tick = baud_9600_tick;
      next_baud_600_tick = baud_600_tick;
      if (fast_count >= 16'(HALF_FAST - 1))
      begin
         next_fast_count = 16'h0000;
         next_baud_9600_tick = !baud_9600_tick;
      end
      if (slow_count >= 16'(HALF_SLOW - 1))
      begin
         next_slow_count = 16'h0000;
         next_baud_600_tick = !baud_600_tick;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         fast_count <= 16'h0000;
         slow_count <= 16'h0000;
         baud_9600_tick <= 1'b0;
         baud_600_tick <= 1'b0;
      end
      else
      begin
         fast_count <= next_fast_count;
         slow_count <= next_slow_count;
         baud_9600_tick <= next_baud_9600_tick;
         baud_600_tick <= next_baud_600_tick;
      end
   end

   // Alert causes
   always_comb
   begin
      alert_level = i_carrier_loss | i_reversal
         | (i_wake_on_ring & i_wake_report_enable)
         | (i_intrusion & i_intrusion_report_enable)
         | (i_loop_loss & i_loop_loss_report_enable & i_off_hook);
   end

   // Pin drive, routing and read data
   always_comb
   begin
      next_pin = 4'h0;
      next_pin_oe = 4'h0;
      next_analog_in_pin = 4'h0;
      next_escape = 1'b0;
      // Pin four
      case (mode_four)
         MGPIO_MODE_OUTPUT:
         begin
            next_pin[3] = pin_data_and_input_gain[3];
            next_pin_oe[3] = 1'b1;
         end
         MGPIO_MODE_ANALOG: next_analog_in_pin[3] = 1'b1;
         MGPIO_MODE_SPECIAL:
         begin
            next_pin[3] = alert_level;
            next_pin_oe[3] = 1'b1;
         end
         default: next_pin_oe[3] = 1'b0;
      endcase
      // Pin three
      case (mode_three)
         MGPIO_MODE_OUTPUT:
         begin
            next_pin[2] = pin_data_and_input_gain[2];
            next_pin_oe[2] = 1'b1;
         end
         MGPIO_MODE_ANALOG: next_analog_in_pin[2] = 1'b1;
         MGPIO_MODE_SPECIAL: next_escape = pin_level[2];
         default: next_pin_oe[2] = 1'b0;
      endcase
      // Pin two
      if (second_port_enable)
      begin
         next_pin[1] = i_control_transmit;
         next_pin_oe[1] = 1'b1;
      end
      else
      begin
         case (mode_two)
            MGPIO_MODE_OUTPUT:
            begin
               next_pin[1] = i_carrier_detect_on_pin ? i_carrier_detect_output
                  : pin_data_and_input_gain[1];
               next_pin_oe[1] = 1'b1;
            end
            MGPIO_MODE_ANALOG: next_analog_in_pin[1] = !frame_end_flag_enable;
            default: next_pin_oe[1] = 1'b0;
         endcase
      end
      // Pin one
      if (frame_end_flag_enable)
      begin
         next_pin[0] = i_frame_end_flag;
         next_pin_oe[0] = 1'b1;
      end
      else if (!second_port_enable)
      begin
         case (mode_one)
            MGPIO_MODE_OUTPUT:
            begin
               next_pin[0] = pin_data_and_input_gain[0];
               next_pin_oe[0] = 1'b1;
            end
            MGPIO_MODE_ANALOG: next_analog_in_pin[0] = 1'b1;
            default: next_pin_oe[0] = 1'b0;
         endcase
      end
      // Serial control source
      if (second_port_enable)
      begin
         next_control_receive = pin_level[0];
         next_primary_transmit = 1'b1;
      end
      else
      begin
         next_control_receive = synced[4];
         next_primary_transmit = i_control_transmit;
      end
      // Routing
      next_serial_loopback = 1'b0;
      case (data_routing_select)
         MGPIO_ROUTE_DATA:
         begin
            next_line_tx_src = MGPIO_SRC_PROC;
            next_analog_out_pin_src = MGPIO_SRC_NONE;
            next_processor_signal_in_src = MGPIO_SRC_LINE;
         end
         MGPIO_ROUTE_VOICE:
         begin
            next_line_tx_src = MGPIO_SRC_AIN;
            next_analog_out_pin_src = MGPIO_SRC_LINE;
            next_processor_signal_in_src = MGPIO_SRC_NONE;
         end
         MGPIO_ROUTE_LOOPBACK:
         begin
            next_line_tx_src = MGPIO_SRC_NONE;
            next_analog_out_pin_src = MGPIO_SRC_AIN;
            next_processor_signal_in_src = MGPIO_SRC_NONE;
            next_serial_loopback = 1'b1;
         end
         MGPIO_ROUTE_CODEC:
         begin
            next_line_tx_src = MGPIO_SRC_NONE;
            next_analog_out_pin_src = MGPIO_SRC_PROC;
            next_processor_signal_in_src = MGPIO_SRC_AIN;
         end
         default:
         begin
            next_line_tx_src = MGPIO_SRC_NONE;
            next_analog_out_pin_src = MGPIO_SRC_NONE;
            next_processor_signal_in_src = MGPIO_SRC_NONE;
         end
      endcase
      // Read data
      case (i_reg_index)
         MGPIO_IDX_PIN_FUNCTION: next_reg_rdata = pin_function_select;
         MGPIO_IDX_PIN_DATA:
         begin
            next_reg_rdata = pin_data_and_input_gain & 8'hC0;
            next_reg_rdata[0] = drives_data(mode_one) ? pin_data_and_input_gain[0]
               : pin_level[0];
            next_reg_rdata[1] = drives_data(mode_two) ? pin_data_and_input_gain[1]
               : pin_level[1];
            next_reg_rdata[2] = drives_data(mode_three) ? pin_data_and_input_gain[2]
               : pin_level[2];
            next_reg_rdata[3] = drives_data(mode_four) ? pin_data_and_input_gain[3]
               : pin_level[3];
         end
         MGPIO_IDX_CHIP_FUNCTIONS:
         begin
            next_reg_rdata = chip_functions_five;
            next_reg_rdata[MGPIO_BIT_BAUD_9600] = baud_9600_tick;
            next_reg_rdata[MGPIO_BIT_BAUD_600] = baud_600_tick;
         end
         default: next_reg_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         o_pin <= 4'h0;
         o_pin_oe <= 4'h0;
         o_analog_in_pin <= 4'h0;
         o_escape <= 1'b0;
         o_primary_transmit <= 1'b1;
         o_control_receive <= 1'b1;
         o_line_tx_src <= MGPIO_SRC_NONE;
         o_analog_out_pin_src <= MGPIO_SRC_NONE;
         o_processor_signal_in_src <= MGPIO_SRC_NONE;
         o_serial_loopback <= 1'b0;
         o_reg_rdata <= 8'h00;
      end
      else
      begin
         o_pin <= next_pin;
         o_pin_oe <= next_pin_oe;
         o_analog_in_pin <= next_analog_in_pin;
         o_escape <= next_escape;
         o_primary_transmit <= next_primary_transmit;
         o_control_receive <= next_control_receive;
         o_line_tx_src <= next_line_tx_src;
         o_analog_out_pin_src <= next_analog_out_pin_src;
         o_processor_signal_in_src <= next_processor_signal_in_src;
         o_serial_loopback <= next_serial_loopback;
         o_reg_rdata <= next_reg_rdata;
      end
   end

   assign o_analog_power_on = chip_functions_five[MGPIO_BIT_ANALOG_POWER];
   assign o_analog_input_gain = pin_data_and_input_gain[MGPIO_FLD_GAIN +: 2];
endmodule // mgpio_top
`default_nettype wire

//--- inc/mgpio_pkg.sv
// Purpose: Shared constants for the modem pin and routing control block
// Assumes: 50 MHz core clock, registers reached by index over a simple port
// Notes:   All reset values are zero, the divider counts included, except o_primary_transmit and o_control_receive, which reset high
package mgpio_pkg;
   // Register indices on the register port
   localparam logic [3:0] MGPIO_IDX_PIN_FUNCTION = 4'h2;
   localparam logic [3:0] MGPIO_IDX_PIN_DATA = 4'h3;
   localparam logic [3:0] MGPIO_IDX_CHIP_FUNCTIONS = 4'h4;
   // Reset values
   localparam logic [7:0] MGPIO_PIN_FUNCTION_RST = 8'h00;
   localparam logic [7:0] MGPIO_PIN_DATA_RST = 8'h00;
   localparam logic [7:0] MGPIO_CHIP_FUNCTIONS_RST = 8'h00;
   // Pin function field positions (low bit of each 2-bit field)
   localparam int MGPIO_FLD_PIN_ONE = 0;
   localparam int MGPIO_FLD_PIN_TWO = 2;
   localparam int MGPIO_FLD_PIN_THREE = 4;
   localparam int MGPIO_FLD_PIN_FOUR = 6;
   // Pin data register fields
   localparam int MGPIO_FLD_GAIN = 6;
   localparam logic [7:0] MGPIO_PIN_DATA_MASK = 8'hCF;
   // Chip function register fields
   localparam int MGPIO_BIT_BAUD_9600 = 7;
   localparam int MGPIO_BIT_BAUD_600 = 6;
   localparam int MGPIO_FLD_ROUTING = 4;
   localparam int MGPIO_BIT_FRAME_END = 3;
   localparam int MGPIO_BIT_ANALOG_POWER = 1;
   localparam int MGPIO_BIT_SECOND_PORT = 0;
   localparam logic [7:0] MGPIO_CHIP_WRITE_MASK = 8'h3B;
   // Pin modes
   typedef enum logic [1:0]
   {
      MGPIO_MODE_INPUT = 2'b00,
      MGPIO_MODE_OUTPUT = 2'b01,
      MGPIO_MODE_ANALOG = 2'b10,
      MGPIO_MODE_SPECIAL = 2'b11
   } mgpio_mode_type;
   // Data routing modes
   typedef enum logic [1:0]
   {
      MGPIO_ROUTE_DATA = 2'b00,
      MGPIO_ROUTE_VOICE = 2'b01,
      MGPIO_ROUTE_LOOPBACK = 2'b10,
      MGPIO_ROUTE_CODEC = 2'b11
   } mgpio_route_type;
   // Source codes for the analog and processor paths
   localparam logic [1:0] MGPIO_SRC_NONE = 2'b00;
   localparam logic [1:0] MGPIO_SRC_LINE = 2'b01;
   localparam logic [1:0] MGPIO_SRC_AIN = 2'b10;
   localparam logic [1:0] MGPIO_SRC_PROC = 2'b11;
   // Baud clock indications: half periods in core clock cycles
   localparam int MGPIO_CLK_HZ = 50_000_000;
   localparam int MGPIO_BAUD_FAST = 9600;
   localparam int MGPIO_BAUD_SLOW = 600;
   localparam int MGPIO_HALF_FAST = MGPIO_CLK_HZ / (2 * MGPIO_BAUD_FAST);
   localparam int MGPIO_HALF_SLOW = MGPIO_CLK_HZ / (2 * MGPIO_BAUD_SLOW);
   // Synchronised inputs: four pins and the primary receive line
   localparam int MGPIO_SYNC_WIDTH = 5;
endpackage

//--- design/mgpio_sync.sv
// Purpose: Two flip-flop synchroniser for pin inputs
// Assumes: Inputs are asynchronous to i_clk
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ps
`default_nettype none
module mgpio_sync
   import mgpio_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Levels
   input wire logic [MGPIO_SYNC_WIDTH-1:0] i_async,
   output logic [MGPIO_SYNC_WIDTH-1:0] o_sync
);
   logic [MGPIO_SYNC_WIDTH-1:0] stage_one;
   logic [MGPIO_SYNC_WIDTH-1:0] stage_two;
   logic [MGPIO_SYNC_WIDTH-1:0] next_stage_one;
   logic [MGPIO_SYNC_WIDTH-1:0] next_stage_two;

   always_comb
   begin
      next_stage_one = i_async;
      next_stage_two = stage_one;
   end

   always_ff @(posedge i_clk)
   begin
      if (!i_nrst)
      begin
         stage_one <= '0;
         stage_two <= '0;
      end
      else
      begin
         stage_one <= next_stage_one;
         stage_two <= next_stage_two;
      end
   end

   assign o_sync = stage_two;
endmodule // mgpio_sync
`default_nettype wire

//--- test/mgpio_top_monitor.sv
// Purpose: Port assertions for the modem pin control block
// Assumes: Register shadows follow the write strobe
// Notes:   Bound to mgpio_top
`timescale 1ns/1ps
`default_nettype none
module mgpio_top_monitor
   import mgpio_pkg::*;
(
   // Clock, reset and register port
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [3:0] i_reg_index,
   input wire logic i_reg_write,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   // Pins
   input wire logic [3:0] i_pin,
   input wire logic [3:0] o_pin,
   input wire logic [3:0] o_pin_oe,
   input wire logic [3:0] o_analog_in_pin,
   input wire logic o_escape,
   // Alert causes
   input wire logic i_carrier_loss,
   input wire logic i_reversal,
   input wire logic i_wake_on_ring,
   input wire logic i_wake_report_enable,
   input wire logic i_intrusion,
   input wire logic i_intrusion_report_enable,
   input wire logic i_loop_loss,
   input wire logic i_loop_loss_report_enable,
   input wire logic i_off_hook,
   // Pin one and two functions and analog power
   input wire logic i_frame_end_flag,
   input wire logic i_control_transmit,
   input wire logic o_primary_transmit,
   input wire logic o_analog_power_on
);
   logic [7:0] fn, dat, chip, next_fn, next_dat, next_chip;
   wire logic plain = !chip[3] && !chip[0];
   wire logic alert = i_carrier_loss || i_reversal || (i_wake_on_ring && i_wake_report_enable)
      || (i_intrusion && i_intrusion_report_enable)
      || (i_loop_loss && i_loop_loss_report_enable && i_off_hook);
   always_comb
   begin
      next_fn = fn;
      next_dat = dat;
      next_chip = chip;
      if (i_reg_write && i_reg_index == MGPIO_IDX_PIN_FUNCTION)
         next_fn = i_reg_wdata;
      if (i_reg_write && i_reg_index == MGPIO_IDX_PIN_DATA)
         next_dat = i_reg_wdata;
      if (i_reg_write && i_reg_index == MGPIO_IDX_CHIP_FUNCTIONS)
         next_chip = i_reg_wdata & MGPIO_CHIP_WRITE_MASK;
      if (!i_nrst)
      begin
         next_fn = 8'h00;
         next_dat = 8'h00;
         next_chip = 8'h00;
      end
   end
   always_ff @(posedge i_clk)
   begin
      fn <= next_fn;
      dat <= next_dat;
      chip <= next_chip;
   end
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_nrst);
   sequence s_alert_held;
      (fn[7:6] == 2'b11) [*2];
   endsequence
   sequence s_port_held;
      chip[0] [*2];
   endsequence
   a_alert_pin: assert property (s_alert_held |-> o_pin_oe[3] && o_pin[3] == $past(alert))
      else $error("alert pin wrong");
   a_escape_in: assert property ((fn[5:4] == 2'b11
      && $past(i_pin[2], 3) == $past(i_pin[2], 2)) [*3] |-> o_escape == $past(i_pin[2], 2))
      else $error("escape level wrong");
   a_escape_off: assert property ((fn[5:4] != 2'b11) [*2] |-> !o_escape)
      else $error("escape active outside its mode");
   a_pin_out: assert property ((fn[1:0] == 2'b01 && plain) [*2] |->
      o_pin_oe[0] && o_pin[0] == $past(dat[0])) else $error("pin one output wrong");
   a_pin_hiz: assert property ((fn[1:0] == 2'b00 && plain) [*2] |-> !o_pin_oe[0])
      else $error("pin one driven as input");
   a_analog_two: assert property ((fn[3:2] == 2'b10 && plain) [*2] |->
      o_analog_in_pin[1] && !o_pin_oe[1]) else $error("pin two analog wrong");
   a_frame_flag: assert property ((chip[3] && !chip[0]) [*2] |->
      o_pin_oe[0] && o_pin[0] == $past(i_frame_end_flag)) else $error("frame flag pin wrong");
   a_second_port: assert property (s_port_held |-> o_pin_oe[1] && o_primary_transmit
      && o_pin[1] == $past(i_control_transmit)) else $error("second port wrong");
   a_power_on: assert property (i_reg_write && i_reg_index == MGPIO_IDX_CHIP_FUNCTIONS
      |=> o_analog_power_on == $past(i_reg_wdata[1])) else $error("analog power wrong");
   a_chip_read: assert property ($past(i_reg_index) == MGPIO_IDX_CHIP_FUNCTIONS |->
      o_reg_rdata[5:0] == $past(chip[5:0])) else $error("chip register read wrong");
   a_unmapped_zero: assert property ($past(i_reg_index) != MGPIO_IDX_PIN_FUNCTION &&
      $past(i_reg_index) != MGPIO_IDX_PIN_DATA && $past(i_reg_index) != MGPIO_IDX_CHIP_FUNCTIONS
      |-> o_reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule // mgpio_top_monitor
bind mgpio_top mgpio_top_monitor i_mon (.i_clk, .i_nrst, .i_reg_index, .i_reg_write,
   .i_reg_wdata, .o_reg_rdata, .i_pin, .o_pin, .o_pin_oe, .o_analog_in_pin, .o_escape,
   .i_carrier_loss, .i_reversal, .i_wake_on_ring, .i_wake_report_enable, .i_intrusion,
   .i_intrusion_report_enable, .i_loop_loss, .i_loop_loss_report_enable, .i_off_hook,
   .i_frame_end_flag, .i_control_transmit, .o_primary_transmit, .o_analog_power_on);
`default_nettype wire

//--- test/mgpio_host.sv
// Purpose: Host controller model driving the register port
// Assumes: Inputs change one ns after the rising edge
// Notes:   Refuses to set frame flag and second port together
`timescale 1ns/1ps
`default_nettype none
module mgpio_host
(
   // Register port
   input wire logic i_clk,
   input wire logic [7:0] i_rdata,
   output logic [3:0] o_index,
   output logic o_write,
   output logic [7:0] o_wdata
);
   initial
   begin
      o_index = 4'h0;
      o_write = 1'b0;
      o_wdata = 8'h00;
   end
   task automatic put(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] v;
      v = d;
      if (idx == 4'h4 && v[3] && v[0])
         v[3] = 1'b0;
      @(posedge i_clk);
      #1;
      o_index = idx;
      o_wdata = v;
      o_write = 1'b1;
      @(posedge i_clk);
      #1;
      o_write = 1'b0;
      o_wdata = ~v;
   endtask
   task automatic get(input logic [3:0] idx, output logic [7:0] d);
      @(posedge i_clk);
      #1;
      o_index = idx;
      repeat (2) @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
endmodule // mgpio_host
`default_nettype wire

//--- test/mgpio_top_bench.sv
// Purpose: Self-checking bench for the modem pin control block
// Assumes: Shortened baud half periods
// Notes:   Pins resolve from drive enables and outside levels
`timescale 1ns/1ps
`default_nettype none
module mgpio_top_bench;
   import mgpio_pkg::*;
   localparam int HF = 4;
   localparam int HS = 8;
   localparam logic [31:0] ROUTE_MASK = 32'hCEF2_323E;
   localparam logic [31:0] ROUTE_EXP = 32'hC490_2238;
   logic i_clk, i_nrst, wr, esc, ptx, crx, lb, analog_power_on, cdo, cdp, ffl, prx, ctx;
   logic [3:0] idx, ext, opin, oe, analog_in_pin;
   logic [7:0] wd, rd, v, e;
   logic [8:0] cs;
   logic [1:0] txs, aos, pis, gain;
   wire logic [3:0] pins = (oe & opin) | (~oe & ext);
   int failures, checks_done, n, k, fn, dat, m;
   mgpio_host i_mgpio_host (.i_clk(i_clk), .i_rdata(rd), .o_index(idx), .o_write(wr),
      .o_wdata(wd));
   mgpio_top #(.HALF_FAST(HF), .HALF_SLOW(HS)) i_mgpio_top (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_reg_index(idx), .i_reg_write(wr), .i_reg_wdata(wd), .o_reg_rdata(rd),
      .i_pin(pins), .o_pin(opin), .o_pin_oe(oe), .o_analog_in_pin(analog_in_pin), .o_escape(esc),
      .i_carrier_loss(cs[0]), .i_reversal(cs[1]), .i_wake_on_ring(cs[2]),
      .i_wake_report_enable(cs[3]), .i_intrusion(cs[4]), .i_intrusion_report_enable(cs[5]),
      .i_loop_loss(cs[6]), .i_loop_loss_report_enable(cs[7]), .i_off_hook(cs[8]),
      .i_carrier_detect_output(cdo), .i_carrier_detect_on_pin(cdp), .i_frame_end_flag(ffl),
      .i_primary_receive(prx), .o_primary_transmit(ptx), .i_control_transmit(ctx),
      .o_control_receive(crx), .o_line_tx_src(txs), .o_analog_out_pin_src(aos),
      .o_processor_signal_in_src(pis), .o_serial_loopback(lb), .o_analog_power_on(analog_power_on),
      .o_analog_input_gain(gain));
   initial
   begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge i_clk);
      #1;
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      #400000;
      failures++;
      summarize();
   end
   initial
   begin
      {i_nrst, cdo, cdp, ffl, prx, ctx, ext, cs} = '0;
      v = $urandom(32'h0000_c64a);
      cyc(16);
      i_nrst = 1'b1;
      // Reset values and an unmapped place
      for (int i = 2; i < 6; i++)
      begin
         i_mgpio_host.get(4'(i), v);
         chk("reset read", v & (i == 4 ? 8'h3F : 8'hFF), 8'h00);
      end
      // Read-only baud bits
      i_mgpio_host.put(4'h4, 8'hC4);
      i_mgpio_host.get(4'h4, v);
      chk("chip read", v[5:0], 8'h00);
      n = 0;
      k = 0;
      repeat (64)
      begin
         cyc(1);
         n += (rd[7] !== v[7]);
         k += (rd[6] !== v[6]);
         v = rd;
      end
      chk("fast baud", 8'(n), 8'(64 / HF));
      chk("slow baud", 8'(k), 8'(64 / HS));
      // Random pin modes and data
      repeat (10)
      begin
         fn = ($urandom % 3) | ($urandom % 3) << 2 | ($urandom % 3) << 4 | ($urandom % 3) << 6;
         dat = $urandom & 8'hCF;
         ext = 4'($urandom);
         i_mgpio_host.put(4'h2, 8'(fn));
         i_mgpio_host.put(4'h3, 8'(dat));
         cyc(4);
         e = 8'(dat) & 8'hC0;
         for (int j = 0; j < 4; j++)
         begin
            m = (fn >> (2 * j)) & 3;
            e[j] = (m == 1) ? dat[j] : ext[j];
            chk("pin drive", oe[j], m == 1);
            chk("analog marker", analog_in_pin[j], m == 2);
            if (m == 1)
               chk("pin out", opin[j], dat[j]);
         end
         chk("gain", gain, dat[7:6]);
         i_mgpio_host.get(4'h3, v);
         chk("pin data read", v, e);
      end
      // Alert causes on pin four
      i_mgpio_host.put(4'h2, 8'hC0);
      repeat (16)
      begin
         cs = 9'($urandom);
         cyc(3);
         m = cs[0] | cs[1] | (cs[2] & cs[3]) | (cs[4] & cs[5]) | (cs[6] & cs[7] & cs[8]);
         chk("alert", {opin[3], oe[3]}, {m[0], 1'b1});
      end
      // Escape input on pin three
      i_mgpio_host.put(4'h2, 8'h30);
      for (int b = 0; b < 2; b++)
      begin
         ext[2] = b[0];
         cyc(5);
         chk("escape", esc, b[0]);
      end
      i_mgpio_host.put(4'h2, 8'h15);
      i_mgpio_host.put(4'h3, 8'h00);
      cdo = 1'b1;
      cdp = 1'b1;
      cyc(4);
      chk("escape off", esc, 0);
      chk("carrier on pin two", opin[1], 1);
      // Routing modes and analog power
      for (int r = 0; r < 4; r++)
      begin
         i_mgpio_host.put(4'h4, 8'((r << 4) | 2));
         cyc(3);
         chk("power", analog_power_on, 1);
         v = {txs, aos, pis, lb, 1'b0};
         chk("route", v & ROUTE_MASK[8*(3-r) +: 8], ROUTE_EXP[8*(3-r) +: 8]);
      end
      // Frame flag on pin one
      ffl = 1'b1;
      i_mgpio_host.put(4'h4, 8'h08);
      cyc(3);
      chk("frame flag", {opin[0], oe[0], analog_power_on}, 3'b110);
      ffl = 1'b0;
      cyc(3);
      chk("frame flag low", opin[0], 0);
      // Second serial port
      i_mgpio_host.put(4'h4, 8'h01);
      for (int b = 0; b < 2; b++)
      begin
         ctx = b[0];
         prx = b[0];
         ext[0] = ~b[0];
         cyc(5);
         chk("second transmit", {opin[1], oe[1], oe[0]}, {b[0], 2'b10});
         chk("second receive", crx, !b[0]);
         chk("primary idle", ptx, 1);
      end
      i_mgpio_host.put(4'h4, 8'h00);
      cyc(5);
      chk("primary back", {ptx, crx}, {ctx, prx});
      summarize();
   end
endmodule // mgpio_top_bench
`default_nettype wire
